// [hxd_decoder.v]
`timescale 1ns/1ps
`default_nettype none
`include "hxd_consts.vh"
module hxd_decoder
#(
  parameter BUF_DEPTH = 256
)
(
  input  wire        clock,
  input  wire        nrst,
  input  wire        char_valid,
  input  wire [7:0]  char_data,
  output reg         byte_valid,
  output reg  [7:0]  byte_data,
  output reg  [15:0] byte_addr,
  output reg         record_done,
  output reg         record_error,
  output reg         file_end
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_COUNT = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_TYPE  = 3'h3;
  localparam [2:0] ST_DATA  = 3'h4;
  localparam [2:0] ST_CHECK = 3'h5;

  // Bytes are buffered per record so bad records emit nothing
  reg  [7:0]  mem_q [0:BUF_DEPTH-1];
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         nib_q;
  reg  [3:0]  hi_q;
  reg  [1:0]  fld_q;
  reg  [7:0]  record_byte_count_field_q;
  reg  [15:0] record_offset_field_q;
  reg  [7:0]  record_type_field_q;
  reg  [7:0]  sum_q;
  reg  [7:0]  idx_q;
  reg         emit_q;
  reg  [7:0]  emit_idx_q;
  reg  [7:0]  emit_cnt_q;
  reg  [15:0] emit_base_q;
  reg  [3:0]  nib_val;
  reg         is_hex;

  wire [7:0]  ascii_data_pair = {hi_q, nib_val};
  wire [7:0]  sum_next        = sum_q + ascii_data_pair;
  wire        is_colon        = (char_data == `HXD_CHAR_COLON);
  wire        in_record       = (state_q != ST_IDLE);
  wire        take_char       = char_valid && !is_colon && in_record;
  wire        bad_char        = take_char && !is_hex;
  wire        high_nib        = take_char && is_hex && !nib_q;
  wire        pair_done       = take_char && is_hex && nib_q;
  wire        last_data       = (idx_q + 8'h01 == record_byte_count_field_q);
  wire        last_emit       = (emit_idx_q + 8'h01 == emit_cnt_q);
  wire        check_end       = pair_done && (state_q == ST_CHECK);
  wire        sum_ok          = (sum_next == `HXD_BYTE_ZERO);
  wire        is_eof          = (record_type_field_q == `HXD_TYPE_EOF);
  wire        has_data        = (record_type_field_q == `HXD_TYPE_DATA) && // R10
                                (record_byte_count_field_q != `HXD_BYTE_ZERO);
  wire        arm_emit        = check_end && sum_ok && has_data;

  always @*
  begin
    is_hex = 1'b1;
    nib_val = 4'h0;
    if (char_data >= `HXD_CHAR_DIG_LO && char_data <= `HXD_CHAR_DIG_HI)
      nib_val = char_data[3:0];
    else if ((char_data >= `HXD_CHAR_UC_LO && char_data <= `HXD_CHAR_UC_HI) ||
             (char_data >= `HXD_CHAR_LC_LO && char_data <= `HXD_CHAR_LC_HI))
      nib_val = char_data[3:0] + `HXD_ALPHA_ADJ; // R5
    else
      is_hex = 1'b0; // R11
  end

  always @*
  begin
    state_d = state_q;
    if (char_valid && is_colon)
      state_d = ST_COUNT; // R1
    else if (bad_char)
      state_d = ST_IDLE; // R11
    else if (pair_done)
    begin
      case (state_q)
        ST_COUNT:
          state_d = ST_ADDR; // R2
        ST_ADDR:
        begin
          if (fld_q == `HXD_ADDR_LAST_PAIR)
            state_d = ST_TYPE; // R3
        end
        ST_TYPE:
        begin
          // Empty records skip straight to the checksum pair
          if (record_byte_count_field_q == `HXD_BYTE_ZERO)
            state_d = ST_CHECK; // R4
          else
            state_d = ST_DATA;
        end
        ST_DATA:
        begin
          if (last_data)
            state_d = ST_CHECK; // R7
        end
        ST_CHECK:
          state_d = ST_IDLE; // R6
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // Emission reads each byte before the next record's data can overwrite it
  always @(posedge clock)
  begin
    if (pair_done && state_q == ST_DATA)
      mem_q[idx_q] <= ascii_data_pair; // R5
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_IDLE;
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      fld_q <= 2'h0;
      record_byte_count_field_q <= 8'h00;
      record_offset_field_q <= 16'h0000;
      record_type_field_q <= 8'h00;
      sum_q <= 8'h00;
      idx_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (char_valid && is_colon)
      begin
        nib_q <= 1'b0; // R1
        fld_q <= 2'h0;
        sum_q <= 8'h00;
        idx_q <= 8'h00;
      end
      else if (high_nib)
      begin
        hi_q <= nib_val;
        nib_q <= 1'b1;
      end
      else if (pair_done)
      begin
        nib_q <= 1'b0; // R5
        sum_q <= sum_next; // R6
        case (state_q)
          ST_COUNT:
            record_byte_count_field_q <= ascii_data_pair; // R2
          ST_ADDR:
          begin
            record_offset_field_q <= {record_offset_field_q[7:0], ascii_data_pair}; // R3
            fld_q <= fld_q + 2'h1;
          end
          ST_TYPE:
            record_type_field_q <= ascii_data_pair; // R4
          ST_DATA:
            idx_q <= idx_q + 8'h01;
          default:
            fld_q <= fld_q;
        endcase
      end
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      record_done <= 1'b0;
      record_error <= 1'b0;
      file_end <= 1'b0;
    end
    else
    begin
      record_done <= check_end && sum_ok; // R6
      record_error <= bad_char || (check_end && !sum_ok); // R11
      // Address-extension records only pulse done; flash space is 16 bit
      file_end <= check_end && sum_ok && is_eof; // R8
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      emit_q <= 1'b0;
      emit_idx_q <= 8'h00;
      emit_cnt_q <= 8'h00;
      emit_base_q <= 16'h0000;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      byte_addr <= 16'h0000;
    end
    else
    begin
      byte_valid <= emit_q; // R7
      if (emit_q)
      begin
        byte_data <= mem_q[emit_idx_q];
        byte_addr <= emit_base_q + {8'h00, emit_idx_q}; // R10
        emit_idx_q <= emit_idx_q + 8'h01;
        if (last_emit)
          emit_q <= 1'b0;
      end
      // A fresh checked data record with a nonzero count restarts emission from its first byte
      if (arm_emit)
      begin
        emit_q <= 1'b1; // R7
        emit_idx_q <= 8'h00;
        emit_cnt_q <= record_byte_count_field_q;
        emit_base_q <= record_offset_field_q; // R9
      end
    end
  end
endmodule // hxd_decoder
`default_nettype wire

// [hxd_consts.vh]
// Notes on behaviour
// R1: A record opens with colon, then count, address, type; ends with checksum pair.
// R2: First two hex characters after colon give the record's data byte count.
// R3: Next four hex characters give the 16-bit address of the first byte.
// R4: Type field: 00 data, 01 end, 02 to 05 address records.
// R5: Each pair of hex characters combines into one byte value.
// R6: Eight-bit sum of all record bytes including checksum must be zero.
// R7: Data record bytes go out at consecutive addresses from the start address.
// R8: A type 01 record marks the end of the file.
// R9: Full address adds shifted linear and segment parts to the offset; this decoder uses the 16-bit offset alone.
// R10: Types 02 to 05 are ignored; only low 16 address bits are used.
// R11: Bad checksum or non-hex character inside a record flags an error, no data.
`ifndef HXD_CONSTS_VH
`define HXD_CONSTS_VH
`define HXD_CHAR_COLON     8'h3a
`define HXD_CHAR_DIG_LO    8'h30
`define HXD_CHAR_DIG_HI    8'h39
`define HXD_CHAR_UC_LO     8'h41
`define HXD_CHAR_UC_HI     8'h46
`define HXD_CHAR_LC_LO     8'h61
`define HXD_CHAR_LC_HI     8'h66
`define HXD_ALPHA_ADJ      4'h9
`define HXD_TYPE_DATA      8'h00
`define HXD_TYPE_EOF       8'h01
`define HXD_BYTE_ZERO      8'h00
`define HXD_ADDR_LAST_PAIR 2'h1
`endif

// [hxd_decoder_chk_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module hxd_decoder_chk (
  input wire logic clock,
  input wire logic nrst,
  input wire logic char_valid,
  input wire logic byte_valid,
  input wire logic record_done,
  input wire logic record_error,
  input wire logic file_end
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_EXCL: assert property (!(record_done && record_error)) else $error("clash");
  AST_EOF: assert property (file_end |-> record_done) else $error("eof");
  AST_EOF_NB: assert property (file_end |=> !byte_valid [*2]) else $error("eof");
  AST_LEAD: assert property ($rose(byte_valid) |-> $past(record_done)) else $error("lead");
  AST_ERR_NB: assert property (record_error |=> !byte_valid [*3]) else $error("err");
  AST_DONE_T: assert property (record_done |-> $past(char_valid)) else $error("done");
  AST_ERR_T: assert property (record_error |-> $past(char_valid)) else $error("err");
  AST_DONE_1: assert property (record_done |=> !record_done) else $error("done");
endmodule // hxd_decoder_chk
bind hxd_decoder hxd_decoder_chk chk_u (
  .clock        (clock),
  .nrst         (nrst),
  .char_valid   (char_valid),
  .byte_valid   (byte_valid),
  .record_done  (record_done),
  .record_error (record_error),
  .file_end     (file_end)
);
`default_nettype wire

// [hxd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hxd_host_model (
  input wire logic clock,
  output var logic char_valid = 1'b0,
  output var logic [7:0] char_data = 8'h00
);
  task automatic send(string t);
    for (int i = 0; i < t.len(); i++)
      @(negedge clock) {char_valid, char_data} = {1'b1, t[i]};
    // Idle line flips so stale chars never look valid
    @(negedge clock) {char_valid, char_data} = {1'b0, ~char_data};
  endtask
endmodule // hxd_host_model
`default_nettype wire

// [hxd_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("FAIL %0t %h %h", $time, a, b); end end
module hex_object_record_decoder_tb_top;
  logic clock = 1'b0, nrst = 1'b0, char_valid, byte_valid, record_done, record_error, file_end;
  logic [7:0] char_data, byte_data;
  logic [15:0] byte_addr;
  int err_count, tests_run;
  bit [7:0] ok, bad, eof, nb;
  hxd_host_model host_u (
    .clock      (clock),
    .char_valid (char_valid),
    .char_data  (char_data)
  );
  hxd_decoder dut_u (
    .clock        (clock),
    .nrst         (nrst),
    .char_valid   (char_valid),
    .char_data    (char_data),
    .byte_valid   (byte_valid),
    .byte_data    (byte_data),
    .byte_addr    (byte_addr),
    .record_done  (record_done),
    .record_error (record_error),
    .file_end     (file_end)
  );
  initial forever #2 clock = ~clock;
  initial #9000 tally_and_finish(1'b1);
  always @(posedge clock)
    if (byte_valid === 1'b1) `CHK({byte_addr, byte_data}, {16'h0100 + 16'(nb), nb})
  always @(posedge clock)
    {ok, bad, eof, nb} <= {ok + record_done, bad + record_error, eof + file_end, nb + byte_valid};
  task automatic run(string s, bit [31:0] e);
    {ok, bad, eof, nb} = '0;
    host_u.send(s);
    repeat (40) @(negedge clock);
    `CHK({ok, bad, eof, nb}, e)
  endtask
  task automatic t_types;
    for (int k = 2; k <= 5; k++)
      run($sformatf(":0200000%0d0108%02x", k, 8'(8'hf5 - k)), 32'h01000000);
  endtask
  task automatic t_data;
    run(":0401000000010203F5", 32'h01000004);
    run(":00000001FF", 32'h01000100);
  endtask
  task automatic t_bad;
    run(":0401000000010203F4", 32'h00010000);
    run(":04010000000G", 32'h00010000);
    run(":0401:00000001FF", 32'h01000100);
  endtask
  task automatic t_reset;
    {ok, bad, eof, nb} = '0;
    host_u.send(":0401000000010203F5");
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    `CHK({ok, bad, eof, nb}, 32'h00000000)
    run(":00000001FF", 32'h01000100);
  endtask
  task tally_and_finish(bit hung);
    err_count += int'(hung);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    t_types();
    t_data();
    t_bad();
    t_reset();
    tally_and_finish(1'b0);
  end
endmodule // hex_object_record_decoder_tb_top
`default_nettype wire
